// file: core/pmc_pkg.sv
// Constants shared by the power-mode and system-clock controller.
// Assumes AHB-Lite register access with 32-bit words, one register per word.
package pmc_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [7:0]  POWER_CONTROL_IDX    = 8'h87;
    localparam logic [7:0]  CLOCK_CONTROL_IDX    = 8'hd8;
    localparam logic [7:0]  AUX_CONTROL2_IDX     = 8'hf7;
    localparam logic [9:0]  POWER_CONTROL_ADDR   = {POWER_CONTROL_IDX, 2'b00};
    localparam logic [9:0]  CLOCK_CONTROL_ADDR   = {CLOCK_CONTROL_IDX, 2'b00};
    localparam logic [9:0]  AUX_CONTROL2_ADDR    = {AUX_CONTROL2_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Power control register fields
    // ------------------------------------------------------------------
    localparam int          PWR_IDLE_BIT         = 0;
    localparam int          PWR_PDOWN_BIT        = 1;
    localparam logic [7:0]  PWR_RESET            = 8'h00;
    localparam logic [7:0]  PWR_STORE_MASK       = 8'h8c;

    // ------------------------------------------------------------------
    // Clock control register fields
    // ------------------------------------------------------------------
    localparam int          CLK_DIV_LSB          = 0;
    localparam int          CLK_SRC_SEL_BIT      = 2;
    localparam int          CLK_FAST_HALT_BIT    = 3;
    localparam int          CLK_PERIPH_GATE_BIT  = 4;
    localparam int          CLK_SLOW_STOP_BIT    = 5;
    localparam int          CLK_FAST_TYPE_BIT    = 6;
    localparam int          CLK_SLOW_TYPE_BIT    = 7;
    localparam logic [7:0]  CLK_RESET            = 8'h23;

    // ------------------------------------------------------------------
    // Auxiliary control register 2 fields
    // ------------------------------------------------------------------
    localparam int          AUX_BANDGAP_BIT      = 4;
    localparam logic [7:0]  AUX_RESET            = 8'h06;
    localparam logic [7:0]  AUX_STORE_MASK       = 8'hf7;

    // ------------------------------------------------------------------
    // Prescaler codes, bandgap channel, timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  DIV_BY_16            = 2'b00;
    localparam logic [1:0]  DIV_BY_4             = 2'b01;
    localparam logic [1:0]  DIV_BY_2             = 2'b10;
    localparam logic [1:0]  DIV_BY_1             = 2'b11;
    localparam logic [3:0]  BANDGAP_CHANNEL      = 4'b1011;
    localparam int          DIV_SETTLE_CYCLES    = 16;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_HALT,
        MODE_STOP
    } pmc_mode_type;

endpackage

// file: core/pmc_power_clock_ctrl.sv
// Power-mode and system-clock controller with an AHB-Lite register slave.
// Assumes oscillator ticks arrive as one-cycle enables on i_clock and that
// wake-up requests come from the interrupt controller on the same clock.
//
// Function
// - Fast mode runs CPU from fast clock, slow mode from slow clock.
// - Writing idle request stops the CPU while peripherals keep running.
// - Idle allowed with either fast or slow clock selected.
// - Peripheral gate in idle stops timers 0-2, UARTs, ADC; timer3 and pins live.
// - Idle ends on reset or any enabled interrupt wake-up.
// - Power-down request with slow clock stop select set enters stop.
// - Stop halts all clocks except an enabled watchdog clock.
// - Stop ends only on reset or pin wake-up.
// - Power-down request with slow clock stop select clear enters halt.
// - Halt stops all clocks except enabled timer3 and watchdog.
// - Halt ends on reset, pin wake-up or timer3 interrupt.
// - Halt or stop refused while an enabled external interrupt pin is low.
// - Source select: 0 slow, 1 fast; writable only while fast clock runs.
// - Prescaler codes 00,01,10,11 divide by 16,4,2,1.
// - New prescaler setting takes effect within 16 clock cycles.
// - Bandgap reaches pin P3.2 when enabled and ADC channel is 1011b.
`timescale 1ns/1ps
module pmc_power_clock_ctrl #(
    parameter int N_EXT_IRQ = 3
) (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    input  wire logic        i_fast_tick,
    input  wire logic        i_slow_tick,
    input  wire logic        i_wdt_tick,
    input  wire logic        i_wdt_enable,
    input  wire logic        i_timer3_enable,
    input  wire logic        i_timer3_irq,
    input  wire logic        i_irq_wake,
    input  wire logic        i_pin_wake,
    input  wire logic [N_EXT_IRQ-1:0] i_ext_irq_pin,
    input  wire logic [N_EXT_IRQ-1:0] i_ext_irq_enable,
    input  wire logic [3:0]  i_adc_channel_select,
    output logic             o_cpu_clk_en,
    output logic             o_periph_clk_en,
    output logic             o_timer3_clk_en,
    output logic             o_wdt_clk_en,
    output logic             o_fast_osc_run,
    output logic             o_slow_osc_run,
    output logic             o_fast_mode,
    output logic [1:0]       o_power_mode,
    output logic             o_entry_refused,
    output logic             o_bandgap_to_pin
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (N_EXT_IRQ < 1 || N_EXT_IRQ > 8) begin : g_bad_irq_count
        $error("N_EXT_IRQ must be 1 to 8");
    end

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic div_hit(input logic [1:0] code, input logic [3:0] cnt);
        logic hit;
        hit = 1'b0;
        case (code)
            pmc_pkg::DIV_BY_16: hit = (cnt == 4'hf);
            pmc_pkg::DIV_BY_4:  hit = (cnt[1:0] == 2'h3);
            pmc_pkg::DIV_BY_2:  hit = cnt[0];
            pmc_pkg::DIV_BY_1:  hit = 1'b1;
            default:            hit = 1'b1;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]              pwr_ff;
    logic [7:0]              clk_ff;
    logic [7:0]              aux_ff;
    logic [7:0]              nxt_clk;
    logic [1:0]              div_active_ff;
    logic [3:0]              div_cnt_ff;
    pmc_pkg::pmc_mode_type   mode_ff;
    pmc_pkg::pmc_mode_type   nxt_mode;
    logic                    wr_pending_ff;
    logic [9:0]              wr_addr_ff;
    logic [31:0]             hrdata_ff;
    logic                    refused_ff;
    logic [N_EXT_IRQ-1:0]    pin_s1_ff;
    logic [N_EXT_IRQ-1:0]    pin_s2_ff;
    logic [N_EXT_IRQ-1:0]    pin_s3_ff;
    logic [N_EXT_IRQ-1:0]    pin_level_ff;
    logic                    addr_phase;
    logic                    wr_pwr;
    logic                    wr_clk;
    logic                    wr_aux;
    logic [7:0]              wdata8;
    logic                    fast_sel;
    logic                    fast_halted;
    logic                    src_tick;
    logic                    sys_tick;
    logic                    entry_block;
    logic                    req_idle;
    logic                    req_pdown;
    logic                    wake;
    logic                    run_or_idle;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    assign addr_phase  = i_hsel && i_hready && i_htrans[1];
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = hrdata_ff;
    assign wdata8      = i_hwdata[7:0];
    assign wr_pwr      = wr_pending_ff && (wr_addr_ff == pmc_pkg::POWER_CONTROL_ADDR);
    assign wr_clk      = wr_pending_ff && (wr_addr_ff == pmc_pkg::CLOCK_CONTROL_ADDR);
    assign wr_aux      = wr_pending_ff && (wr_addr_ff == pmc_pkg::AUX_CONTROL2_ADDR);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_pending_ff <= 1'b0;
            wr_addr_ff    <= 10'h000;
        end else begin
            wr_pending_ff <= addr_phase && i_hwrite && (i_haddr[31:10] == 22'h0);
            wr_addr_ff    <= i_haddr[9:0];
        end
    end

    // Read data captured at the address phase; unmapped reads return zero
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite) begin
            case (i_haddr)
                32'(pmc_pkg::POWER_CONTROL_ADDR): hrdata_ff <= {24'h000000, pwr_ff};
                32'(pmc_pkg::CLOCK_CONTROL_ADDR): hrdata_ff <= {24'h000000, clk_ff};
                32'(pmc_pkg::AUX_CONTROL2_ADDR):  hrdata_ff <= {24'h000000, aux_ff};
                default:                          hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock control register with guarded fields
    // ------------------------------------------------------------------
    always_comb begin
        nxt_clk = clk_ff;
        if (wr_clk) begin
            nxt_clk[pmc_pkg::CLK_SLOW_STOP_BIT]   = wdata8[pmc_pkg::CLK_SLOW_STOP_BIT];
            nxt_clk[pmc_pkg::CLK_PERIPH_GATE_BIT] = wdata8[pmc_pkg::CLK_PERIPH_GATE_BIT];
            nxt_clk[pmc_pkg::CLK_DIV_LSB +: 2]    = wdata8[pmc_pkg::CLK_DIV_LSB +: 2];
            if (fast_sel) begin
                nxt_clk[pmc_pkg::CLK_SLOW_TYPE_BIT] = wdata8[pmc_pkg::CLK_SLOW_TYPE_BIT];
            end else begin
                nxt_clk[pmc_pkg::CLK_FAST_TYPE_BIT] = wdata8[pmc_pkg::CLK_FAST_TYPE_BIT];
                nxt_clk[pmc_pkg::CLK_FAST_HALT_BIT] = wdata8[pmc_pkg::CLK_FAST_HALT_BIT];
            end
            if (!fast_halted) begin
                nxt_clk[pmc_pkg::CLK_SRC_SEL_BIT] = wdata8[pmc_pkg::CLK_SRC_SEL_BIT];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_ff <= pmc_pkg::CLK_RESET;
        end else begin
            clk_ff <= nxt_clk;
        end
    end

    assign fast_sel    = clk_ff[pmc_pkg::CLK_SRC_SEL_BIT];
    assign fast_halted = clk_ff[pmc_pkg::CLK_FAST_HALT_BIT];

    // ------------------------------------------------------------------
    // Auxiliary register and bandgap routing
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            aux_ff <= pmc_pkg::AUX_RESET;
        end else if (wr_aux) begin
            aux_ff <= wdata8 & pmc_pkg::AUX_STORE_MASK;
        end
    end

    // Left on in low power unless firmware clears it first
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bandgap_to_pin <= 1'b0;
        end else begin
            o_bandgap_to_pin <= aux_ff[pmc_pkg::AUX_BANDGAP_BIT]
                && (i_adc_channel_select == pmc_pkg::BANDGAP_CHANNEL);
        end
    end

    // ------------------------------------------------------------------
    // External interrupt pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1_ff    <= '1;
            pin_s2_ff    <= '1;
            pin_s3_ff    <= '1;
            pin_level_ff <= '1;
        end else begin
            pin_s1_ff <= i_ext_irq_pin;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < N_EXT_IRQ; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_level_ff[i] <= pin_s3_ff[i];
                end
            end
        end
    end

    assign entry_block = |(~pin_level_ff & i_ext_irq_enable);

    // ------------------------------------------------------------------
    // Power mode sequencing
    // ------------------------------------------------------------------
    assign req_idle  = wr_pwr && wdata8[pmc_pkg::PWR_IDLE_BIT];
    assign req_pdown = wr_pwr && wdata8[pmc_pkg::PWR_PDOWN_BIT];

    always_comb begin
        wake = 1'b0;
        case (mode_ff)
            pmc_pkg::MODE_IDLE: wake = i_irq_wake || i_pin_wake || i_timer3_irq;
            pmc_pkg::MODE_HALT: wake = i_pin_wake || i_timer3_irq;
            pmc_pkg::MODE_STOP: wake = i_pin_wake;
            default:            wake = 1'b0;
        endcase
    end

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            pmc_pkg::MODE_RUN: begin
                if (req_pdown && !entry_block) begin
                    if (clk_ff[pmc_pkg::CLK_SLOW_STOP_BIT]) begin
                        nxt_mode = pmc_pkg::MODE_STOP;
                    end else begin
                        nxt_mode = pmc_pkg::MODE_HALT;
                    end
                end else if (req_idle) begin
                    nxt_mode = pmc_pkg::MODE_IDLE;
                end
            end
            pmc_pkg::MODE_IDLE,
            pmc_pkg::MODE_HALT,
            pmc_pkg::MODE_STOP: begin
                if (wake) begin
                    nxt_mode = pmc_pkg::MODE_RUN;
                end
            end
            default: nxt_mode = pmc_pkg::MODE_RUN;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_ff <= pmc_pkg::MODE_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Request bits read back while the mode lasts, cleared on return to run
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_ff <= pmc_pkg::PWR_RESET;
        end else begin
            if (wr_pwr) begin
                pwr_ff <= (wdata8 & pmc_pkg::PWR_STORE_MASK)
                    | {6'h00, nxt_mode == pmc_pkg::MODE_HALT || nxt_mode == pmc_pkg::MODE_STOP,
                       nxt_mode == pmc_pkg::MODE_IDLE};
            end else if (nxt_mode == pmc_pkg::MODE_RUN) begin
                pwr_ff[pmc_pkg::PWR_IDLE_BIT]  <= 1'b0;
                pwr_ff[pmc_pkg::PWR_PDOWN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            refused_ff <= 1'b0;
        end else if (wr_pwr) begin
            refused_ff <= req_pdown && entry_block;
        end
    end

    // ------------------------------------------------------------------
    // System clock divider
    // ------------------------------------------------------------------
    assign src_tick = fast_sel ? (i_fast_tick && !fast_halted) : i_slow_tick;
    assign sys_tick = src_tick && div_hit(div_active_ff, div_cnt_ff);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_cnt_ff <= 4'h0;
        end else if (src_tick && (mode_ff != pmc_pkg::MODE_HALT)
                     && (mode_ff != pmc_pkg::MODE_STOP)) begin
            div_cnt_ff <= div_cnt_ff + 4'h1;
        end
    end

    // New divisor adopted at the wrap of the 16-count
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_active_ff <= pmc_pkg::CLK_RESET[1:0];
        end else if (src_tick && (div_cnt_ff == 4'hf)) begin
            div_active_ff <= clk_ff[pmc_pkg::CLK_DIV_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Clock enables per mode
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cpu_clk_en    <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_timer3_clk_en <= 1'b0;
            o_wdt_clk_en    <= 1'b0;
            o_fast_osc_run  <= 1'b0;
            o_slow_osc_run  <= 1'b0;
        end else begin
            o_wdt_clk_en    <= i_wdt_tick && i_wdt_enable;
            o_cpu_clk_en    <= sys_tick && (mode_ff == pmc_pkg::MODE_RUN);
            o_periph_clk_en <= sys_tick && (mode_ff == pmc_pkg::MODE_RUN
                || (mode_ff == pmc_pkg::MODE_IDLE && !clk_ff[pmc_pkg::CLK_PERIPH_GATE_BIT]));
            o_timer3_clk_en <= run_or_idle ? sys_tick
                : (mode_ff == pmc_pkg::MODE_HALT) && i_slow_tick && i_timer3_enable;
            o_fast_osc_run  <= run_or_idle && !fast_halted;
            o_slow_osc_run  <= run_or_idle
                || ((mode_ff == pmc_pkg::MODE_HALT) && i_timer3_enable);
        end
    end

    assign run_or_idle = (mode_ff == pmc_pkg::MODE_RUN) || (mode_ff == pmc_pkg::MODE_IDLE);

    assign o_fast_mode     = fast_sel;
    assign o_power_mode    = mode_ff;
    assign o_entry_refused = refused_ff;

endmodule

// file: verification/pmc_ctrl_asserts.sv
// Port assertions for the power-mode and clock controller.
// Assumes a bind onto pmc_power_clock_ctrl with a single clock domain.
`timescale 1ns/1ps
module pmc_ctrl_asserts (
    input wire logic       i_clock,
    input wire logic       i_nrst,
    input wire logic       i_wdt_tick,
    input wire logic       i_wdt_enable,
    input wire logic       i_timer3_irq,
    input wire logic       i_irq_wake,
    input wire logic       i_pin_wake,
    input wire logic [3:0] i_adc_channel_select,
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    input wire logic       o_cpu_clk_en,
    input wire logic       o_periph_clk_en,
    input wire logic       o_timer3_clk_en,
    input wire logic       o_wdt_clk_en,
    input wire logic       o_slow_osc_run,
    input wire logic       o_fast_osc_run,
    input wire logic [1:0] o_power_mode,
    input wire logic       o_entry_refused,
    input wire logic       o_bandgap_to_pin
);
    // ----------------------------------------------------------------
    // Mode, gating and bus properties
    // ----------------------------------------------------------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    property p_bus_ok; o_hreadyout && !o_hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus wait or error seen");
    property p_wdt; 1 |=> o_wdt_clk_en == $past(i_wdt_tick && i_wdt_enable); endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clock wrong");
    property p_stop_gate; o_power_mode == 2'd3 && $past(o_power_mode) == 2'd3
        |-> !o_cpu_clk_en && !o_timer3_clk_en && !o_slow_osc_run && !o_fast_osc_run; endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clock alive in stop");
    property p_halt_gate; o_power_mode == 2'd2 && $past(o_power_mode) == 2'd2
        |-> !o_cpu_clk_en && !o_periph_clk_en && !o_fast_osc_run; endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("clock alive in halt");
    property p_idle_cpu; o_power_mode == 2'd1 && $past(o_power_mode) == 2'd1
        |-> !o_cpu_clk_en; endproperty
    a_idle_cpu: assert property (p_idle_cpu) else $error("cpu clock in idle");
    property p_stop_hold; (o_power_mode == 2'd3 && !i_pin_wake) [*2] |=> o_power_mode == 2'd3;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without pin");
    property p_stop_wake; o_power_mode == 2'd3 && i_pin_wake |-> ##[1:2] o_power_mode == 2'd0;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop not left");
    property p_halt_wake; o_power_mode == 2'd2 && (i_pin_wake || i_timer3_irq)
        |-> ##[1:2] o_power_mode == 2'd0; endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not left");
    property p_idle_wake; o_power_mode == 2'd1 && (i_irq_wake || i_pin_wake || i_timer3_irq)
        |-> ##[1:2] o_power_mode == 2'd0; endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
    property p_refused; o_entry_refused |-> o_power_mode == 2'd0; endproperty
    a_refused: assert property (p_refused) else $error("refused yet in low power");
    property p_bandgap; o_bandgap_to_pin
        |-> $past(i_adc_channel_select) == pmc_pkg::BANDGAP_CHANNEL; endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap on other channel");
endmodule

bind pmc_power_clock_ctrl pmc_ctrl_asserts pmc_ctrl_asserts_i (
    .i_clock, .i_nrst, .i_wdt_tick, .i_wdt_enable, .i_timer3_irq, .i_irq_wake, .i_pin_wake,
    .i_adc_channel_select, .o_hreadyout, .o_hresp, .o_cpu_clk_en, .o_periph_clk_en,
    .o_timer3_clk_en, .o_wdt_clk_en, .o_slow_osc_run, .o_fast_osc_run, .o_power_mode,
    .o_entry_refused, .o_bandgap_to_pin);

// file: verification/testbench.sv
// Self-checking bench for the power-mode and clock controller.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] A_PWR = 32'(pmc_pkg::POWER_CONTROL_ADDR);
    localparam logic [31:0] A_CLK = 32'(pmc_pkg::CLOCK_CONTROL_ADDR);
    localparam logic [31:0] A_AUX = 32'(pmc_pkg::AUX_CONTROL2_ADDR);
    logic        i_clock = 0, i_nrst = 0, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0, mode;
    logic        f_tick = 0, s_tick = 0, cpu_en, per_en, wdt_en, fast, refused, bg;
    logic [2:0]  wake = 0, pins = 3'h7, ext_en = 0;
    logic [3:0]  chan = 0;
    int          n_fail = 0, cmp_count = 0, cycles = 0;

    pmc_power_clock_ctrl pmc_power_clock_ctrl_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_fast_tick(f_tick), .i_slow_tick(s_tick), .i_wdt_tick(s_tick),
        .i_wdt_enable(1'b1), .i_timer3_enable(1'b1), .i_timer3_irq(wake[1]),
        .i_irq_wake(wake[2]), .i_pin_wake(wake[0]), .i_ext_irq_pin(pins),
        .i_ext_irq_enable(ext_en), .i_adc_channel_select(chan), .o_cpu_clk_en(cpu_en),
        .o_periph_clk_en(per_en), .o_timer3_clk_en(), .o_wdt_clk_en(wdt_en),
        .o_fast_osc_run(), .o_slow_osc_run(), .o_fast_mode(fast),
        .o_power_mode(mode), .o_entry_refused(refused), .o_bandgap_to_pin(bg));

    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        @(posedge i_clock);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge i_clock); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic count(output logic [31:0] n);
        repeat (20) @(negedge i_clock);
        n = 0;
        repeat (64) begin
            @(negedge i_clock);
            n = n + cpu_en;
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] rd, a[4] = '{A_PWR, A_CLK, A_AUX, 32'h3f0}, e[4] = '{0, 32'h23, 32'h6, 0};
        for (int i = 0; i < 4; i++) begin
            bus(0, a[i], 0, rd);
            check("reset_value", rd, e[i]);
        end
        check("fast_mode", fast, 0);
        $display("reset test done");
    endtask
    task automatic t_clock;
        logic [31:0] rd;
        logic [7:0]  w[9] = '{'h27, 'h2f, 'h23, 'h2b, 'h2f, 'he3, 'ha7, 'ha7, 'h23};
        logic [7:0]  e[9] = '{'h27, 'h27, 'h23, 'h2b, 'h2b, 'h63, 'h27, 'ha7, 'h23};
        for (int i = 0; i < 9; i++) begin
            bus(1, A_CLK, 32'(w[i]), rd);
            bus(0, A_CLK, 0, rd);
            check("clock_reg", rd, 32'(e[i]));
            check("fast_mode", fast, 32'(e[i][2]));
        end
        $display("clock select test done");
    endtask
    task automatic t_div;
        logic [31:0] rd, n;
        int sh[4] = '{4, 2, 1, 0};
        for (int c = 0; c < 4; c++) begin
            bus(1, A_CLK, 32'h20 | c, rd);
            count(n);
            check("div_ticks", n, 64 >> sh[c]);
        end
        bus(1, A_CLK, 32'h27, rd);
        count(n);
        check("fast_no_tick", n, 0);
        @(posedge i_clock) {f_tick, s_tick} <= 2'b10;
        count(n);
        check("fast_ticks", n, 64);
        @(posedge i_clock) {f_tick, s_tick} <= 2'b01;
        bus(1, A_CLK, 32'h23, rd);
        $display("prescaler test done");
    endtask
    task automatic t_mode(input logic [7:0] clk, pwr, input logic [1:0] md,
                          input logic pe, input logic [2:0] bad, good);
        logic [31:0] rd;
        bus(1, A_CLK, 32'(clk), rd);
        bus(1, A_PWR, 32'(pwr), rd);
        repeat (2) @(negedge i_clock);
        check("mode", mode, 32'(md));
        check("cpu_en", cpu_en, 0);
        check("periph_en", per_en, 32'(pe));
        check("wdt_en", wdt_en, 1);
        @(posedge i_clock) wake <= bad;
        repeat (4) @(negedge i_clock);
        check("mode_hold", mode, 32'(md));
        @(posedge i_clock) wake <= good;
        repeat (3) @(negedge i_clock);
        check("mode_woken", mode, 0);
        check("cpu_resumed", cpu_en, 1);
        @(posedge i_clock) wake <= 0;
        bus(0, A_CLK, 0, rd);
        check("clock_kept", rd, 32'(clk));
        $display("mode %0d test done", md);
    endtask
    task automatic t_refuse;
        logic [31:0] rd;
        @(posedge i_clock) {ext_en, pins} <= {3'b010, 3'b101};
        repeat (6) @(posedge i_clock);
        bus(1, A_PWR, 32'h2, rd);
        repeat (2) @(negedge i_clock);
        check("refused_mode", mode, 0);
        check("refused_flag", refused, 1);
        @(posedge i_clock) ext_en <= 3'b101;
        repeat (6) @(posedge i_clock);
        t_mode(8'h23, 8'h02, 2'd3, 1'b0, 3'b110, 3'b001);
        check("refused_clear", refused, 0);
        @(posedge i_clock) pins <= 3'h7;
    endtask
    task automatic t_bandgap;
        logic [31:0] rd;
        bus(1, A_AUX, 32'h16, rd);
        @(posedge i_clock) chan <= 4'b1011;
        repeat (3) @(negedge i_clock);
        check("bandgap_on", bg, 1);
        @(posedge i_clock) chan <= 4'b1010;
        repeat (3) @(negedge i_clock);
        check("bandgap_chan", bg, 0);
        bus(0, A_AUX, 0, rd);
        check("aux_reg", rd, 32'h16);
        bus(1, 32'h3e0, 32'hff, rd);
        bus(0, 32'h3e0, 0, rd);
        check("unmapped", rd, 0);
        $display("bandgap test done");
    endtask

    initial begin
        repeat (12) @(posedge i_clock);
        i_nrst <= 1;
        s_tick <= 1;
        t_reset();
        t_clock();
        t_div();
        t_mode(8'h23, 8'h01, 2'd1, 1'b1, 3'b000, 3'b100);
        t_mode(8'h33, 8'h01, 2'd1, 1'b0, 3'b000, 3'b010);
        t_mode(8'h03, 8'h02, 2'd2, 1'b0, 3'b100, 3'b010);
        t_mode(8'h23, 8'h03, 2'd3, 1'b0, 3'b110, 3'b001);
        t_refuse();
        t_bandgap();
        finish_test();
    end
endmodule
